// File: bench/tws_slave_model.sv
// Purpose: behavioural two-wire slave receiver for the bench
// Assumes: bus resolved as wired-and with pull-ups in the bench
// Notes:   can stretch the clock low phase after each byte
`timescale 1ns/10ps
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_stretch,
  output logic            o_sda_oe,
  output logic            o_scl_oe,
  output logic [7:0]      o_last
);
  logic [7:0] sh = 8'h00;
  int         n = 0;
  bit         sel = 0;
  bit         first = 0;
  // data line released until addressed; clock low phase stretched after every byte
  initial begin
    o_sda_oe = 1'b0;
    o_scl_oe = 1'b0;
    o_last = 8'h00;
  end
  always @(negedge i_sda) begin
    if (i_scl) begin
      n = 0;
      first = 1;
      sel = 0;
    end
  end
  always @(posedge i_scl) begin
    if (n < 8) sh = {sh[6:0], i_sda};
    n = n + 1;
  end
  // ack own write address and its bytes
  always @(negedge i_scl) begin
    if (n == 8) begin
      if (first) sel = (sh[7:1] == ADDR) && !sh[0];
      else if (sel) o_last = sh;
      first = 0;
      o_sda_oe <= sel;
      // slow slave: the master must wait out this low phase
      if (i_stretch) begin
        o_scl_oe = 1'b1;
        #400;
        o_scl_oe = 1'b0;
      end
    end else if (n == 9) begin
      o_sda_oe <= 1'b0;
      n = 0;
    end
  end
endmodule : tws_slave_model

// File: bench/tws_top_tb.sv
// Purpose: self-checking bench for the two-wire serial block
// Assumes: shortened bit time and timeouts
// Notes:   master write, repeated start, nack, stop, slave receive, arbitration
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_top_tb;
  localparam logic [6:0] SADR = 7'h5a;
  logic        i_clk = 0;
  logic        i_rst_n = 0;
  logic [3:0]  av_a = 4'h0;
  logic        av_r = 0;
  logic        av_w = 0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rd;
  logic        av_wait;
  logic        scl_oe;
  logic        sda_oe;
  logic        s_scl_oe;
  logic        s_sda_oe;
  logic [7:0]  s_last;
  logic        m_scl_oe = 0;
  logic        m_sda_oe = 0;
  logic        nak;
  logic [31:0] seed = 32'h1c7c;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          checked = 0;
  logic [7:0]  exp_q[$];
  // wired-and bus with pull-ups; the bench may act as a second master
  wire scl = !(scl_oe | s_scl_oe | m_scl_oe);
  wire sda = !(sda_oe | s_sda_oe | m_sda_oe);
  initial begin
    forever #2.5 i_clk = !i_clk;
  end
  tws_top #(.HALF_CYC(11), .FREE_CYC(200), .LOW_TO_CYC(2000)) tws_top_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(av_a), .i_avs_read(av_r),
    .i_avs_write(av_w), .i_avs_writedata(av_wd), .i_avs_byteenable(4'h1),
    .o_avs_readdata(av_rd), .o_avs_waitrequest(av_wait), .i_scl(scl), .i_sda(sda),
    .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe));
  tws_slave_model #(.ADDR(SADR)) tws_slave_model_i (
    .i_scl(scl), .i_sda(sda), .i_stretch(1'b1), .o_sda_oe(s_sda_oe),
    .o_scl_oe(s_scl_oe), .o_last(s_last));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checked++;
    if ((got & m) !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one bus access; held until waitrequest seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    av_a <= a;
    av_wd <= {24'h0, d};
    av_w <= w;
    av_r <= !w;
    do begin
      @(posedge i_clk);
      k++;
    end while (av_wait !== 1'b0 && k < 100);
    q = av_rd;
    av_w <= 1'b0;
    av_r <= 1'b0;
    if (k >= 100) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge i_clk);
  endtask : acc
  // poll control until the event flag rises, then read state
  task automatic wflag;
    int k;
    for (k = 0; k < 300; k++) begin
      acc(0, `TWS_OFF_CTL, 8'h00);
      if (q[`TWS_B_SI] === 1'b1) break;
    end
    if (k >= 300) begin
      n_mismatch++;
      stop_test();
    end
    acc(0, `TWS_OFF_STA, 8'h00);
  endtask : wflag
  task automatic step(input logic [7:0] d, input logic [7:0] c, input logic [31:0] code);
    acc(1, `TWS_OFF_DAT, d);
    acc(1, `TWS_OFF_CTL, c);
    wflag();
    chk(q, code, 32'h3ff);
  endtask : step
  // bench as master: one clock, data set while low; waits out a stretched low phase
  task automatic mclk(input logic b, output logic r);
    int k;
    repeat (2) @(posedge i_clk);
    m_sda_oe <= !b;
    repeat (12) @(posedge i_clk);
    m_scl_oe <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (scl !== 1'b1 && k < 300);
    if (k >= 300) begin
      n_mismatch++;
      stop_test();
    end
    repeat (12) @(posedge i_clk);
    r = sda;
    m_scl_oe <= 1'b1;
  endtask : mclk
  // eight bits msb first, then the ninth clock returns the answer (1 = nack)
  task automatic mbyte(input logic [7:0] d, output logic r);
    for (int i = 7; i >= 0; i--) mclk(d[i], r);
    mclk(1'b1, r);
  endtask : mbyte
  // start (data falls, clock high) or stop (clock released, then data rises)
  task automatic mline(input logic stp);
    m_sda_oe <= 1'b1;
    repeat (12) @(posedge i_clk);
    m_scl_oe <= !stp;
    repeat (12) @(posedge i_clk);
    if (stp) m_sda_oe <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : mline
  initial begin
    int k;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    acc(0, `TWS_OFF_STA, 8'h00);
    chk(q, 32'h3f8, 32'h3ff);
    acc(0, 4'h2, 8'h00);
    chk(q, 32'h0, 32'hffffffff);
    $display("test reset done");
    acc(1, `TWS_OFF_ADR, 8'h22);
    acc(1, `TWS_OFF_CTL, 8'h64);
    wflag();
    chk(q, 32'h08, 32'hff);
    step({SADR, 1'b0}, 8'h44, 32'h018);
    // random bytes, expected from the queue model
    repeat (2) begin
      seed = xs(seed);
      exp_q.push_back(seed[7:0]);
      step(seed[7:0], 8'h44, 32'h028);
      chk({24'h0, s_last}, {24'h0, exp_q.pop_front()}, 32'hff);
    end
    $display("test write done");
    acc(1, `TWS_OFF_CTL, 8'h64);
    wflag();
    chk(q, 32'h10, 32'hff);
    step({~SADR, 1'b0}, 8'h44, 32'h020);
    acc(1, `TWS_OFF_CTL, 8'h54);
    for (k = 0; k < 300; k++) begin
      acc(0, `TWS_OFF_CTL, 8'h00);
      if (q[7] === 1'b0 && q[`TWS_B_STO] === 1'b0) break;
    end
    if (k >= 300) n_mismatch++;
    chk(q, 32'h0, 32'h90);
    $display("test stop done");
    // bench master writes one random byte to the block as slave
    mline(0);
    mbyte(8'h22, nak);
    chk({31'h0, nak}, 32'h0, 32'h1);
    wflag();
    chk(q, 32'h360, 32'h3ff);
    acc(1, `TWS_OFF_CTL, 8'h44);
    seed = xs(seed);
    exp_q.push_back(seed[7:0]);
    mbyte(seed[7:0], nak);
    chk({31'h0, nak}, 32'h0, 32'h1);
    wflag();
    chk(q, 32'h380, 32'h3ff);
    acc(0, `TWS_OFF_DAT, 8'h00);
    chk(q, {24'h0, exp_q.pop_front()}, 32'hff);
    acc(1, `TWS_OFF_CTL, 8'h44);
    mline(1);
    wflag();
    chk(q, 32'h3a0, 32'h3ff);
    // ack flag cleared: own address ignored, no flag
    acc(1, `TWS_OFF_CTL, 8'h40);
    mline(0);
    mbyte(8'h22, nak);
    chk({31'h0, nak}, 32'h1, 32'h1);
    mline(1);
    acc(0, `TWS_OFF_CTL, 8'h00);
    chk(q, 32'h40, 32'hff);
    $display("test slave done");
    // bench holds data low while the block sends a one
    acc(1, `TWS_OFF_CTL, 8'h64);
    wflag();
    chk(q, 32'h08, 32'hff);
    m_sda_oe <= 1'b1;
    acc(1, `TWS_OFF_DAT, {SADR, 1'b0});
    acc(1, `TWS_OFF_CTL, 8'h44);
    mbyte(8'h00, nak);
    wflag();
    chk(q, 32'h338, 32'h3ff);
    acc(1, `TWS_OFF_CTL, 8'h44);
    mline(1);
    $display("test arbitration done");
    stop_test();
  end
endmodule : tws_top_tb

// File: common/tws_consts.svh
// Purpose: constants of the two-wire serial block
// Assumes: included by bare name
// Notes:   byte offsets, bit positions, state codes, timing
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_CLK_MHZ     200
`define TWS_LOW_TO_US   25000
`define TWS_FREE_US     50
`define TWS_HALF_NS     5000
`define TWS_OFF_CTL     4'h0
`define TWS_OFF_DAT     4'h4
`define TWS_OFF_ADR     4'h8
`define TWS_OFF_STA     4'hc
`define TWS_B_ENA       6
`define TWS_B_STA       5
`define TWS_B_STO       4
`define TWS_B_SI        3
`define TWS_B_AA        2
`define TWS_GC_ADDR     7'h00
`define TWS_RST_BYTE    8'h00
`define TWS_C_BUSERR    8'h00
`define TWS_C_START     8'h08
`define TWS_C_RSTART    8'h10
`define TWS_C_MT_AACK   8'h18
`define TWS_C_MT_ANAK   8'h20
`define TWS_C_MT_DACK   8'h28
`define TWS_C_MT_DNAK   8'h30
`define TWS_C_ARB       8'h38
`define TWS_C_MR_AACK   8'h40
`define TWS_C_MR_ANAK   8'h48
`define TWS_C_MR_DACK   8'h50
`define TWS_C_MR_DNAK   8'h58
`define TWS_C_SR_ADR    8'h60
`define TWS_C_SR_ARB    8'h68
`define TWS_C_SR_GC     8'h70
`define TWS_C_SR_DACK   8'h80
`define TWS_C_SR_DNAK   8'h88
`define TWS_C_SR_STOP   8'ha0
`define TWS_C_ST_ADR    8'ha8
`define TWS_C_ST_ARB    8'hb0
`define TWS_C_ST_DACK   8'hb8
`define TWS_C_ST_DNAK   8'hc0
`define TWS_C_IDLE      8'hf8
`endif

// File: common/tws_pkg.sv
// Purpose: types of the two-wire serial block
// Assumes: nothing
// Notes:   used by scoped name only
package tws_pkg;
  typedef enum logic [1:0] {MODE_MT, MODE_MR, MODE_ST, MODE_SR} tws_mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_XFER, ST_HOLD, ST_STOP} tws_state_e;
endpackage : tws_pkg

// File: rtl/tws_top.sv
// Purpose: byte-oriented two-wire serial master/slave with Avalon-MM registers
// Assumes: open-drain pads outside; lines synchronised to i_clk here
// Notes:   one register access takes two cycles
// Function
// [R1] software moves whole bytes; hardware shifts bits alone
// [R2] master, slave, clock generation and sync, arbitration, start/stop
// [R3] first byte: address in bits 7-1, direction in bit 0
// [R4] direction one reads, zero writes
// [R5] receiver pulls data low on ninth clock to acknowledge
// [R6] only masters start; they finish with stop
// [R7] master starts only on a free bus
// [R8] losing arbitration drops to slave receiver without glitch
// [R9] master waits for clock really high before counting high phase
// [R10] clock low beyond 25 ms resets communication
// [R11] lines high over 50 us frees the bus
// [R12] master transmitter: start, address write, bytes with ack, stop
// [R13] master receiver: address read, bytes, ack per ack flag, stop
// [R14] slave acknowledges own seven bit address
// [R15] slave acknowledges general call when enable bit set
// [R16] slave transmitter sends on master clock until stop
// [R17] slave receiver acks per ack flag until stop
// [R18] exactly one of four modes, readable with state code
// [R19] lines only pulled low or released
// [R20] state entry sets event flag; flag holds clock low
// [R21] start flag makes master; waits busy bus; repeated start
// [R22] stop flag sends stop, then start if asked; cleared on stop
// [R23] cleared ack flag answers nack and ignores addresses
// [R24] start and stop detected from sampled lines
// [R25] master keeps data stable while clock high
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_top #(
  parameter int HALF_CYC   = `TWS_HALF_NS * `TWS_CLK_MHZ / 1000,
  parameter int FREE_CYC   = `TWS_FREE_US * `TWS_CLK_MHZ,
  parameter int LOW_TO_CYC = `TWS_LOW_TO_US * `TWS_CLK_MHZ
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl_o,
  output logic             o_scl_oe,
  output logic             o_sda_o,
  output logic             o_sda_oe
);
  logic                 scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic                 enable, start_req, stop_req, si, ack_assert, busy;
  logic [7:0]           data_reg, own_addr, code, shreg;
  tws_pkg::tws_mode_e   mode;
  tws_pkg::tws_state_e  state;
  logic [1:0]           phase;
  logic [15:0]          hcnt;
  logic [23:0]          low_cnt, free_cnt;
  logic [3:0]           bitcnt;
  logic                 scl_low_drv, sda_gen_low, sda_drv, addr_phase, addressed, lost, rep;
  logic                 ack_drive, ack_rx, rise_seen, si_q, set_si, sto_done, gc_hit;
  logic                 start_det, stop_det, ev_rise, ev_fall, hdone, resume, master, active, tx_now;
  logic                 wr_en, ctl_wr, match, to_hit, free_hit, next_scl_oe, next_sda_oe;

  // two-stage synchronisers; the second stage and its one-cycle delayed copy are looked at
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
    end
  end

  // [R24] bus condition detect
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  assign ev_rise   = scl_s & ~scl_d;
  assign ev_fall   = ~scl_s & scl_d;
  assign hdone     = (hcnt == 16'(HALF_CYC - 1));
  assign resume    = si_q & ~si;
  assign master    = (state != tws_pkg::ST_IDLE);
  assign active    = (state == tws_pkg::ST_XFER) | (~master & (addr_phase | addressed));
  assign tx_now    = master ? (addr_phase | (mode == tws_pkg::MODE_MT)) : (addressed & (mode == tws_pkg::MODE_ST));
  assign wr_en     = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign ctl_wr    = wr_en & (i_avs_address == `TWS_OFF_CTL);
  assign to_hit    = (low_cnt == 24'(LOW_TO_CYC - 1));
  assign free_hit  = (free_cnt == 24'(FREE_CYC - 1));
  // [R14] [R15] [R23] address match, gated by the ack flag
  assign gc_hit    = (shreg[7:1] == `TWS_GC_ADDR) & own_addr[0];
  assign match     = ((shreg[7:1] == own_addr[7:1]) | gc_hit) & ack_assert;

  // bus slave: waitrequest drops one cycle after a request, then rises again
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
    end else begin
      o_avs_waitrequest <= ~(o_avs_waitrequest & (i_avs_read | i_avs_write));
      if (o_avs_waitrequest & i_avs_read) begin
        case (i_avs_address)
          `TWS_OFF_CTL: o_avs_readdata <= {24'h0, busy, enable, start_req, stop_req, si, ack_assert, 2'h0};
          `TWS_OFF_DAT: o_avs_readdata <= {24'h0, data_reg};
          `TWS_OFF_ADR: o_avs_readdata <= {24'h0, own_addr};
          // [R18] mode and state code readback
          `TWS_OFF_STA: o_avs_readdata <= {22'h0, 2'(mode), code};
          default:      o_avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // control flags; a hardware set wins over a software clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {enable, start_req, stop_req, si, ack_assert} <= 5'h0;
      own_addr <= `TWS_RST_BYTE;
      si_q     <= 1'b0;
    end else begin
      si_q <= si;
      if (ctl_wr) begin
        enable     <= i_avs_writedata[`TWS_B_ENA];
        start_req  <= i_avs_writedata[`TWS_B_STA];
        ack_assert <= i_avs_writedata[`TWS_B_AA];
      end
      // [R20] event flag set by hardware, cleared by software
      if (set_si) si <= 1'b1;
      else if (ctl_wr) si <= i_avs_writedata[`TWS_B_SI];
      // [R22] stop flag cleared by a stop on the bus
      if (ctl_wr) stop_req <= i_avs_writedata[`TWS_B_STO];
      else if (stop_det | sto_done) stop_req <= 1'b0;
      if (wr_en & (i_avs_address == `TWS_OFF_ADR)) own_addr <= i_avs_writedata[7:0];
    end
  end

  // [R7] [R11] busy tracking with bus-free timeout
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy     <= 1'b0;
      free_cnt <= 24'h0;
    end else begin
      if (start_det) busy <= 1'b1;
      else if (stop_det | free_hit | to_hit) busy <= 1'b0;
      if (~(scl_s & sda_s)) free_cnt <= 24'h0;
      else if (!free_hit) free_cnt <= free_cnt + 24'h1;
    end
  end

  // [R10] clock-low timeout counter, only while the bus is in use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt <= 24'h0;
    else if (scl_s | ~busy) low_cnt <= 24'h0;
    else if (!to_hit) low_cnt <= low_cnt + 24'h1;
  end

  // protocol engine: master sequencer first, bit events override it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= tws_pkg::ST_IDLE;
      mode  <= tws_pkg::MODE_SR;
      code  <= `TWS_C_IDLE;
      {phase, hcnt, bitcnt} <= 22'h0;
      shreg    <= `TWS_RST_BYTE;
      data_reg <= `TWS_RST_BYTE;
      {scl_low_drv, sda_gen_low, sda_drv, addr_phase, addressed, lost, rep} <= 7'h0;
      {ack_drive, ack_rx, rise_seen, set_si, sto_done} <= 5'h0;
    end else begin
      set_si   <= 1'b0;
      sto_done <= 1'b0;
      if (wr_en & (i_avs_address == `TWS_OFF_DAT)) data_reg <= i_avs_writedata[7:0];
      case (state)
        // [R7] [R21] start only when the bus is free
        tws_pkg::ST_IDLE: begin
          if (start_req & enable & ~busy & ~addressed & ~addr_phase & ~si) begin
            state <= tws_pkg::ST_START;
            phase <= 2'h0;
            hcnt  <= 16'h0;
            rep   <= 1'b0;
          end
        end
        // [R6] [R21] start or repeated start sequence
        tws_pkg::ST_START: begin
          hcnt <= hdone ? 16'h0 : hcnt + 16'h1;
          case (phase)
            2'h0: if (hdone) begin
              scl_low_drv <= 1'b0;
              phase       <= 2'h1;
            end
            2'h1: if (!scl_s) hcnt <= 16'h0;
            else if (hdone) begin
              sda_gen_low <= 1'b1;
              phase       <= 2'h2;
            end
            default: if (hdone) begin
              scl_low_drv <= 1'b1;
              sda_drv     <= 1'b1;
              sda_gen_low <= 1'b0;
              mode        <= tws_pkg::MODE_MT;
              code        <= rep ? `TWS_C_RSTART : `TWS_C_START;
              set_si      <= 1'b1;
              state       <= tws_pkg::ST_HOLD;
            end
          endcase
        end
        // [R20] clock held low until software clears the flag
        tws_pkg::ST_HOLD: begin
          hcnt <= 16'h0;
          phase <= 2'h0;
          if (resume) begin
            if (stop_req) begin
              state       <= tws_pkg::ST_STOP;
              sda_gen_low <= 1'b1;
              sda_drv     <= 1'b0;
            end else if (start_req) begin
              state       <= tws_pkg::ST_START;
              sda_gen_low <= 1'b0;
              sda_drv     <= 1'b0;
              rep         <= 1'b1;
            end else begin
              // [R1] [R12] load the byte software left behind
              state <= tws_pkg::ST_XFER;
              if (tx_now) shreg <= data_reg;
              sda_drv <= tx_now & ~data_reg[7];
            end
          end
        end
        // [R2] clock generation
        tws_pkg::ST_XFER: begin
          if (scl_low_drv) begin
            hcnt <= hdone ? 16'h0 : hcnt + 16'h1;
            if (hdone) scl_low_drv <= 1'b0;
          end else if (!scl_s) begin
            // [R9] stretched clock: high phase counts only once high
            hcnt <= 16'h0;
          end else begin
            hcnt <= hdone ? 16'h0 : hcnt + 16'h1;
            if (hdone) scl_low_drv <= 1'b1;
          end
        end
        // [R6] [R22] stop sequence releases the bus
        tws_pkg::ST_STOP: begin
          hcnt <= hdone ? 16'h0 : hcnt + 16'h1;
          case (phase)
            2'h0: if (hdone) begin
              scl_low_drv <= 1'b0;
              phase       <= 2'h1;
            end
            2'h1: if (!scl_s) hcnt <= 16'h0;
            else if (hdone) begin
              sda_gen_low <= 1'b0;
              phase       <= 2'h2;
            end
            default: if (hdone) state <= tws_pkg::ST_IDLE;
          endcase
        end
        default: state <= tws_pkg::ST_IDLE;
      endcase
      // [R16] slave transmitter loads the next byte on release
      if (resume & ~master & addressed & (mode == tws_pkg::MODE_ST)) begin
        shreg   <= data_reg;
        sda_drv <= ~data_reg[7];
      end
      // [R22] stop flag as slave behaves like a received stop
      if (stop_req & ~master) begin
        addressed  <= 1'b0;
        addr_phase <= 1'b0;
        sda_drv    <= 1'b0;
        mode       <= tws_pkg::MODE_SR;
        sto_done   <= 1'b1;
      end
      // [R5] sample data on the rising clock
      if (active & ev_rise) begin
        rise_seen <= 1'b1;
        if (bitcnt < 4'h8) shreg <= {shreg[6:0], sda_s};
        else ack_rx <= ~sda_s;
        // [R8] released a one but saw a zero: back off quietly
        if ((state == tws_pkg::ST_XFER) & tx_now & (bitcnt < 4'h8) & shreg[7] & ~sda_s) begin
          state       <= tws_pkg::ST_IDLE;
          scl_low_drv <= 1'b0;
          sda_drv     <= 1'b0;
          mode        <= tws_pkg::MODE_SR;
          lost        <= 1'b1;
          if (!addr_phase) begin
            code   <= `TWS_C_ARB;
            set_si <= 1'b1;
          end
        end
      end
      // [R25] data changes only after the clock falls
      if (active & ev_fall & rise_seen) begin
        rise_seen <= 1'b0;
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h8;
          if (master) begin
            // [R13] master receiver ack per flag
            ack_drive <= ~tx_now & ack_assert;
            sda_drv   <= ~tx_now & ack_assert;
          end else if (addr_phase) begin
            if (match) begin
              // [R3] [R4] [R14] [R15] take the direction from bit 0
              ack_drive <= 1'b1;
              sda_drv   <= 1'b1;
              addressed <= 1'b1;
              mode      <= shreg[0] ? tws_pkg::MODE_ST : tws_pkg::MODE_SR;
            end else begin
              addr_phase <= 1'b0;
              bitcnt     <= 4'h0;
              sda_drv    <= 1'b0;
              lost       <= 1'b0;
              if (lost) begin
                code   <= `TWS_C_ARB;
                set_si <= 1'b1;
              end
            end
          end else begin
            // [R17] [R23] slave receiver ack per flag
            ack_drive <= (mode == tws_pkg::MODE_SR) & ack_assert;
            sda_drv   <= (mode == tws_pkg::MODE_SR) & ack_assert;
          end
        end else if (bitcnt == 4'h8) begin
          // [R20] byte done: new state code and event flag
          bitcnt     <= 4'h0;
          ack_drive  <= 1'b0;
          sda_drv    <= 1'b0;
          addr_phase <= 1'b0;
          lost       <= 1'b0;
          set_si     <= 1'b1;
          if (!tx_now) data_reg <= shreg;
          if (master) begin
            state <= tws_pkg::ST_HOLD;
            if (addr_phase) begin
              mode <= shreg[0] ? tws_pkg::MODE_MR : tws_pkg::MODE_MT;
              if (shreg[0]) code <= ack_rx ? `TWS_C_MR_AACK : `TWS_C_MR_ANAK;
              else code <= ack_rx ? `TWS_C_MT_AACK : `TWS_C_MT_ANAK;
            end else if (mode == tws_pkg::MODE_MT) code <= ack_rx ? `TWS_C_MT_DACK : `TWS_C_MT_DNAK;
            else code <= ack_drive ? `TWS_C_MR_DACK : `TWS_C_MR_DNAK;
          end else if (addr_phase) begin
            if (gc_hit & ~shreg[0]) code <= `TWS_C_SR_GC;
            else if (shreg[0]) code <= lost ? `TWS_C_ST_ARB : `TWS_C_ST_ADR;
            else code <= lost ? `TWS_C_SR_ARB : `TWS_C_SR_ADR;
          end else if (mode == tws_pkg::MODE_ST) begin
            // [R16] a nack from the master ends the slave send
            code <= ack_rx ? `TWS_C_ST_DACK : `TWS_C_ST_DNAK;
            if (!ack_rx) addressed <= 1'b0;
          end else code <= ack_drive ? `TWS_C_SR_DACK : `TWS_C_SR_DNAK;
        end else begin
          bitcnt  <= bitcnt + 4'h1;
          sda_drv <= tx_now & ~shreg[7];
        end
      end
      // [R24] start on the bus opens an address byte
      if (start_det) begin
        bitcnt     <= 4'h0;
        addr_phase <= 1'b1;
        rise_seen  <= 1'b0;
        addressed  <= 1'b0;
        ack_drive  <= 1'b0;
      end
      // [R16] [R17] a stop ends slave mode
      if (stop_det) begin
        addressed  <= 1'b0;
        addr_phase <= 1'b0;
        bitcnt     <= 4'h0;
        if (!master) mode <= tws_pkg::MODE_SR;
        if (addressed & ~master) begin
          code   <= `TWS_C_SR_STOP;
          set_si <= 1'b1;
        end
      end
      // [R10] timeout or disable drops everything and frees the lines
      if (!enable | to_hit) begin
        state <= tws_pkg::ST_IDLE;
        mode  <= tws_pkg::MODE_SR;
        bitcnt <= 4'h0;
        {scl_low_drv, sda_gen_low, sda_drv, addr_phase, addressed, ack_drive} <= 6'h0;
        if (to_hit & enable) begin
          code   <= `TWS_C_BUSERR;
          set_si <= 1'b1;
        end
      end
    end
  end

  // [R19] [R20] open-drain drive; slave stretches only when clock low
  assign next_scl_oe = scl_low_drv | (si & addressed & ~master & (o_scl_oe | ~scl_s));
  assign next_sda_oe = ((state == tws_pkg::ST_START) | (state == tws_pkg::ST_STOP)) ? sda_gen_low : sda_drv;

  // pads: level output is always low, only the enable moves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_scl_o, o_scl_oe, o_sda_o, o_sda_oe} <= 4'h0;
    end else begin
      {o_scl_o, o_sda_o} <= 2'h0;
      o_scl_oe <= next_scl_oe;
      o_sda_oe <= next_sda_oe;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_sda_stable;
    (state == tws_pkg::ST_XFER) && $past(state == tws_pkg::ST_XFER) && scl_s && $past(scl_s) |-> $stable(o_sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("data moved while clock high"); // [R25]
  property p_start_free;
    $past(state == tws_pkg::ST_IDLE) && (state == tws_pkg::ST_START) |-> !$past(busy);
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus"); // [R7]
  property p_si_hold;
    si && addressed && !master && !scl_s |=> o_scl_oe;
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("clock not held with flag set"); // [R20]
  property p_stop_clear;
    stop_det && !ctl_wr |=> !stop_req;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop flag not cleared"); // [R22]
  property p_byte_si;
    active && ev_fall && rise_seen && (bitcnt == 4'h8) && enable && !to_hit && !ctl_wr |-> ##2 si;
  endproperty
  a_byte_si: assert property (p_byte_si) else $error("byte end without flag"); // [R20]
  property p_arb;
    $rose(lost) && !start_det |-> (state == tws_pkg::ST_IDLE) && (mode == tws_pkg::MODE_SR) ##1 !o_scl_oe;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss not handled"); // [R8]
  property p_stretch;
    (state == tws_pkg::ST_XFER) && !scl_low_drv && !scl_s && enable |=> !scl_low_drv;
  endproperty
  a_stretch: assert property (p_stretch) else $error("master pulled clock during stretch"); // [R9]
  property p_busy;
    start_det |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("start not marking bus busy"); // [R24]
  property p_wait;
    o_avs_waitrequest && (i_avs_read || i_avs_write) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong"); // [R1]
  c_byte: cover property (active && ev_fall && rise_seen && (bitcnt == 4'h8));
  c_arb: cover property ($rose(lost));
  c_stop: cover property (state == tws_pkg::ST_STOP ##[1:1000] stop_det);
  c_slave: cover property ($rose(addressed));
endmodule : tws_top
